//--- logic/tms_pkg.sv
package tms_pkg;

    // bus addresses of the two variants
    localparam logic [6:0] TMS_ADDR_STD   = 7'h4C;
    localparam logic [6:0] TMS_ADDR_ALT   = 7'h4D;

    // register offsets seen through the pointer
    localparam logic [7:0] TMS_OFS_TRIG   = 8'h0F;
    localparam logic [7:0] TMS_OFS_FILT   = 8'h22;

    // filter/timeout register layout and reset value
    localparam int         TMS_TMO_EN_BIT = 7;
    localparam int         TMS_FILT_LSB   = 1;
    localparam int         TMS_FILT_MSB   = 3;
    localparam logic [7:0] TMS_FILT_RST   = 8'h01;
    localparam logic [7:0] TMS_PTR_RST    = 8'h00;

    // bits per byte slot and write bytes per transfer
    localparam logic [3:0] TMS_BITS       = 4'h8;
    localparam logic [1:0] TMS_MAX_BYTES  = 2'h2;

    // inactivity timeout
    localparam int         TMS_CLK_KHZ    = 125000;
    localparam int         TMS_TMO_MS     = 25;
    localparam int         TMS_TMO_CYC    = TMS_TMO_MS * TMS_CLK_KHZ;
    localparam int         TMS_TMO_W      = 22;

    // transfer phases
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_WRITE,
        ST_ACK_WR,
        ST_READ,
        ST_READ_ACK
    } tms_state_t;

    // whole state of the serial slave
    typedef struct packed
    {
        tms_state_t             state;
        logic [3:0]             cnt;
        logic [7:0]             shift;
        logic                   rw;
        logic [1:0]             byte_idx;
        logic                   sda_low;
        logic [7:0]             ptr;
        logic [7:0]             filt;
        logic                   wr_pulse;
        logic [7:0]             wdata;
        logic                   trig;
        logic [TMS_TMO_W-1:0]   tmo_cnt;
        logic                   scl_q;
        logic                   sda_q;
    } tms_regs_t;

    // register write strobe towards the register file
    typedef struct packed
    {
        logic                   wr;
        logic [7:0]             addr;
        logic [7:0]             data;
    } tms_wr_t;

endpackage

//--- logic/tms_serial_slave.sv
`timescale 1ns/10ps

// Overview of operation
// - write to 0x0F pulses trigger, data dropped
// - bit 7 of 0x22 enables 25 ms timeout
// - standard variant answers address 1001100
// - alternate variant answers address 1001101
// - shift in seven address bits plus direction
// - acknowledge on match, else idle till start
// - direction 0 writes, 1 reads
// - each byte is nine clock pulses
// - direction fixed until a fresh start
// - one or two write bytes, one read byte
// - first byte loads pointer, second writes register
// - read returns pointed register, pointer persists
// - separate read and write addresses possible
// - pointer must be loaded before relying on it
// - 0x22 top bit timeout, bits 3:1 filter
module tms_serial_slave
    import tms_pkg::*;
    #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int TMO_CYCLES  = TMS_TMO_CYC
    )
    (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // serial bus pins
    input  wire logic        serial_clock_i,
    input  wire logic        serial_data_line_i,
    output logic             serial_data_line_o,
    output logic             serial_data_line_oe_o,
    // register file side
    output logic             reg_wr_o,
    output logic [7:0]       reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    input  wire logic [7:0]  reg_rdata_i,
    // one-shot and filter outputs
    output logic             trigger_o,
    output logic [2:0]       alert_filter_o,
    output logic             timeout_en_o
    );

    ////////////////////////////////////////////////////////////////////////////

    tms_regs_t  st_reg;          // registered state
    tms_regs_t  st_next;         // next state
    logic [1:0] pins_sync;       // synced clock (1) and data (0)
    logic       scl_s;           // synced serial clock
    logic       sda_s;           // synced serial data
    logic       scl_rise;        // clock rising edge
    logic       scl_fall;        // clock falling edge
    logic       start_det;       // start condition seen
    logic       stop_det;        // stop condition seen
    logic [6:0] own_addr;        // our bus address
    logic [7:0] rd_byte;         // byte to send on read
    tms_wr_t    wr_bus;          // write strobe bundle

    // parameter checks at elaboration
    initial
    begin
        if (TMO_CYCLES < 1 || TMO_CYCLES >= (1 << TMS_TMO_W))
            $error("timeout count does not fit counter");
    end

    ////////////////////////////////////////////////////////////////////////////

    // bring both bus pins into the clock domain
    tms_sync
        #(
        .WIDTH     (2)
        )
    u_sync
        (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .async_i   ({serial_clock_i, serial_data_line_i}),
        .rst_val_i (2'h3),
        .sync_o    (pins_sync)
        );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////////

    // edge and condition detection on synced lines
    always_comb
    begin
        scl_rise  = scl_s & ~st_reg.scl_q;
        scl_fall  = ~scl_s & st_reg.scl_q;
        // start is falling data while clock high
        start_det = st_reg.scl_q & scl_s & st_reg.sda_q & ~sda_s;
        // rising data while clock high is stop
        stop_det  = st_reg.scl_q & scl_s & ~st_reg.sda_q & sda_s;
    end

    assign own_addr = ALT_VARIANT ? TMS_ADDR_ALT : TMS_ADDR_STD;

    // read data follows pointer, no write alias
    assign rd_byte = (st_reg.ptr == TMS_OFS_FILT) ? st_reg.filt : reg_rdata_i;

    ////////////////////////////////////////////////////////////////////////////

    // transfer state machine and register updates
    always_comb
    begin
        st_next          = st_reg;
        st_next.scl_q    = scl_s;
        st_next.sda_q    = sda_s;
        st_next.wr_pulse = 1'b0;
        st_next.trig     = 1'b0;

        // inactivity counter restarts on any bus edge
        if (st_reg.state == ST_IDLE || scl_s != st_reg.scl_q || sda_s != st_reg.sda_q)
            st_next.tmo_cnt = '0;
        else
            st_next.tmo_cnt = st_reg.tmo_cnt + 1'b1;

        if (stop_det)
        begin
            // stop ends any transfer
            st_next.state   = ST_IDLE;
            st_next.sda_low = 1'b0;
        end
        else if (start_det)
        begin
            st_next.state    = ST_ADDR;
            st_next.cnt      = '0;
            st_next.byte_idx = '0;
            st_next.sda_low  = 1'b0;
        end
        // timeout only when enable bit set
        else if (st_reg.filt[TMS_TMO_EN_BIT] &&
                 st_reg.tmo_cnt >= TMS_TMO_W'(TMO_CYCLES))
        begin
            st_next.state   = ST_IDLE;
            st_next.sda_low = 1'b0;
        end
        else
        begin
            case (st_reg.state)
                ST_IDLE:
                begin
                    // wait for start
                    st_next.sda_low = 1'b0;
                end
                ST_ADDR, ST_WRITE:
                begin
                    // shift in msb first on clock rise
                    if (scl_rise && st_reg.cnt < TMS_BITS)
                    begin
                        st_next.shift = {st_reg.shift[6:0], sda_s};
                        st_next.cnt   = st_reg.cnt + 1'b1;
                    end
                    // eighth bit done, ninth is acknowledge
                    else if (scl_fall && st_reg.cnt == TMS_BITS)
                    begin
                        st_next.cnt = '0;
                        if (st_reg.state == ST_ADDR)
                        begin
                            if (st_reg.shift[7:1] == own_addr)
                            begin
                                st_next.rw      = st_reg.shift[0];
                                st_next.sda_low = 1'b1;
                                st_next.state   = ST_ACK_ADDR;
                            end
                            else
                                st_next.state = ST_IDLE;
                        end
                        else if (st_reg.byte_idx < TMS_MAX_BYTES)
                        begin
                            st_next.sda_low  = 1'b1;
                            st_next.state    = ST_ACK_WR;
                            st_next.byte_idx = st_reg.byte_idx + 1'b1;
                            if (st_reg.byte_idx == 2'h0)
                                st_next.ptr = st_reg.shift;
                            else if (st_reg.ptr == TMS_OFS_TRIG)
                                st_next.trig = 1'b1;
                            else
                            begin
                                st_next.wr_pulse = 1'b1;
                                st_next.wdata    = st_reg.shift;
                                if (st_reg.ptr == TMS_OFS_FILT)
                                    st_next.filt = st_reg.shift;
                            end
                        end
                        else
                            // extra bytes not acknowledged
                            st_next.state = ST_IDLE;
                    end
                end
                ST_ACK_ADDR, ST_ACK_WR:
                begin
                    // release or send first bit after ninth pulse
                    if (scl_fall)
                    begin
                        st_next.cnt = '0;
                        if (st_reg.state == ST_ACK_ADDR && st_reg.rw)
                        begin
                            st_next.shift   = rd_byte;
                            st_next.sda_low = ~rd_byte[7];
                            st_next.state   = ST_READ;
                        end
                        else
                        begin
                            st_next.sda_low = 1'b0;
                            st_next.state   = ST_WRITE;
                        end
                    end
                end
                ST_READ:
                begin
                    // shift out on clock fall
                    if (scl_fall)
                    begin
                        st_next.cnt   = st_reg.cnt + 1'b1;
                        st_next.shift = {st_reg.shift[6:0], 1'b0};
                        if (st_reg.cnt == TMS_BITS - 1'b1)
                        begin
                            st_next.sda_low = 1'b0;
                            st_next.state   = ST_READ_ACK;
                        end
                        else
                            st_next.sda_low = ~st_reg.shift[6];
                    end
                end
                ST_READ_ACK:
                begin
                    // one byte only; idle on the acknowledge clock rise
                    st_next.sda_low = 1'b0;
                    if (scl_rise)
                        st_next.state = ST_IDLE;
                end
                default:
                begin
                    st_next.state   = ST_IDLE;
                    st_next.sda_low = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // state register
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            st_reg          <= '0;
            st_reg.state    <= ST_IDLE;
            st_reg.ptr      <= TMS_PTR_RST;
            st_reg.filt     <= TMS_FILT_RST;
            st_reg.scl_q    <= 1'b1;
            st_reg.sda_q    <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////

    // outputs from registered state
    assign wr_bus.wr             = st_reg.wr_pulse;
    assign wr_bus.addr           = st_reg.ptr;
    assign wr_bus.data           = st_reg.wdata;
    assign reg_wr_o              = wr_bus.wr;
    assign reg_addr_o            = wr_bus.addr;
    assign reg_wdata_o           = wr_bus.data;
    assign trigger_o             = st_reg.trig;
    assign alert_filter_o        = st_reg.filt[TMS_FILT_MSB:TMS_FILT_LSB];
    assign timeout_en_o          = st_reg.filt[TMS_TMO_EN_BIT];
    // open drain: only ever pull low
    assign serial_data_line_o    = 1'b0;
    assign serial_data_line_oe_o = st_reg.sda_low;

endmodule

//--- logic/tms_sync.sv
`timescale 1ns/10ps

// two-flop synchroniser for inputs from outside the clock domain
module tms_sync
    #(
    parameter int WIDTH = 1
    )
    (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0]  async_i,
    input  wire logic [WIDTH-1:0]  rst_val_i,
    output logic      [WIDTH-1:0]  sync_o
    );

    logic [WIDTH-1:0] meta_reg;   // first stage, read only by second

    // check width at elaboration
    initial
    begin
        if (WIDTH < 1)
            $error("tms_sync width must be positive");
    end

    // two stages; reset both to the caller's idle level
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            meta_reg <= rst_val_i;
            sync_o   <= rst_val_i;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule

//--- testbench/tms_bus_master.sv
`timescale 1ns/10ps

// bus master model, lines move at the falling system clock edge
module tms_bus_master
    (
    // pacing clock
    input  wire logic  clock_i,
    // resolved data wire
    input  wire logic  sda_i,
    // master bus lines
    output logic       scl_o,
    output logic       pull_low_o
    );

    // bus idle, clock stands high
    initial
    begin
        scl_o      = 1'h1;
        pull_low_o = 1'h0;
    end

    // quarter of a 64 ns bus period
    task automatic quarter;
        repeat (2) @(negedge clock_i);
    endtask

    task automatic start;
        pull_low_o = 1'h0;
        quarter();
        pull_low_o = 1'h1;
        quarter();
        scl_o = 1'h0;
        quarter();
    endtask

    task automatic clock_bit(input logic b, output logic s);
        pull_low_o = !b;
        quarter();
        scl_o = 1'h1;
        quarter();
        s = sda_i;
        quarter();
        scl_o = 1'h0;
        quarter();
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], s);
        clock_bit(1'h1, s);
        ack = !s;
    endtask

    task automatic recv_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'h1, s);
            d = {d[6:0], s};
        end
        clock_bit(1'h1, s);
    endtask

    // low in clock low, rises in clock high
    task automatic stop;
        pull_low_o = 1'h1;
        quarter();
        scl_o = 1'h1;
        quarter();
        pull_low_o = 1'h0;
        quarter();
    endtask
endmodule

//--- testbench/tms_serial_slave_tb_top.sv
`timescale 1ns/10ps

// bench for the serial slave, both variants on one bus
module tms_serial_slave_tb_top
    import tms_pkg::*;
    ;

    localparam int TMO = 200;           // shortened timeout
    logic          clock_i = 1'h0;      // system clock
    logic          rst_i   = 1'h1;      // sync reset
    logic          scl;                 // bus clock
    logic          m_low;               // master pulls data low
    logic          sda_line;            // resolved data wire
    logic          std_do;              // device data level
    logic          std_oe;              // device pulls low
    logic          alt_oe;              // alternate pulls low
    logic          reg_wr;              // store strobe
    logic [7:0]    ptr;                 // pointer
    logic [7:0]    alt_ptr;             // alternate pointer
    logic [7:0]    wdata;               // store data
    logic [7:0]    last_wd;             // last stored data
    logic          trig;                // one-shot pulse
    logic [2:0]    filt;                // filter field
    logic          tmo_en;              // timeout enable
    logic [3:0]    acks;                // address and byte acks
    logic [7:0]    rd;                  // byte read
    logic [6:0]    bad [3] = '{7'h19, 7'h0C, 7'h4E};  // foreign addresses
    int            error_cnt    = 0;
    int            total_checks = 0;
    int            wr_cnt       = 0;
    int            trg_cnt      = 0;

    always #4 clock_i = ~clock_i;

    // open drain wire with pull-up
    assign sda_line = !m_low && !(std_oe && !std_do) && !alt_oe;

    tms_serial_slave #(.ALT_VARIANT(1'h0), .TMO_CYCLES(TMO)) uut
    (
        .clock_i(clock_i), .rst_i(rst_i), .serial_clock_i(scl), .serial_data_line_i(sda_line),
        .serial_data_line_o(std_do), .serial_data_line_oe_o(std_oe), .reg_wr_o(reg_wr),
        .reg_addr_o(ptr), .reg_wdata_o(wdata), .reg_rdata_i(ptr ^ 8'hC3),
        .trigger_o(trig), .alert_filter_o(filt), .timeout_en_o(tmo_en)
    );
    tms_serial_slave #(.ALT_VARIANT(1'h1), .TMO_CYCLES(TMO)) uut_alt
    (
        .clock_i(clock_i), .rst_i(rst_i), .serial_clock_i(scl), .serial_data_line_i(sda_line),
        .serial_data_line_o(), .serial_data_line_oe_o(alt_oe), .reg_wr_o(), .reg_addr_o(alt_ptr),
        .reg_wdata_o(), .reg_rdata_i(8'h00), .trigger_o(), .alert_filter_o(), .timeout_en_o()
    );
    tms_bus_master bus (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .pull_low_o(m_low));

    // count stores and triggers
    always @(posedge clock_i)
    begin
        if (reg_wr)
        begin
            wr_cnt  <= wr_cnt + 1;
            last_wd <= wdata;
        end
        if (trig)
            trg_cnt <= trg_cnt + 1;
    end

    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // write transfer, up to three bytes
    task automatic write_xfer(input logic [6:0] a, input int n, input logic [23:0] b);
        logic k;
        acks = 4'h0;
        bus.start();
        bus.send_byte({a, 1'h0}, acks[3]);
        for (int i = 0; i < n; i++)
        begin
            bus.send_byte(b[23-8*i -: 8], k);
            acks[2-i] = k;
        end
        bus.stop();
    endtask

    task automatic read_xfer(input logic [6:0] a);
        bus.start();
        bus.send_byte({a, 1'h1}, acks[3]);
        bus.recv_byte(rd);
        bus.stop();
    endtask

    // stall with clock low during the acknowledge
    task automatic stall(input logic released);
        logic s;
        bus.start();
        for (int i = 6; i >= 0; i--)
            bus.clock_bit(TMS_ADDR_STD[i], s);
        bus.clock_bit(1'h0, s);
        repeat (4) @(negedge clock_i);
        check(8'(std_oe), 8'h01);
        repeat (300) @(negedge clock_i);
        check(8'(std_oe), 8'(!released));
        bus.clock_bit(1'h1, s);
        bus.stop();
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog
    initial
    begin
        repeat (40000) @(posedge clock_i);
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge clock_i);
        rst_i = 1'h0;
        repeat (4) @(negedge clock_i);
        check(8'(tmo_en), 8'h00);
        check(8'(filt), 8'h00);
        $display("test reset done");
        write_xfer(TMS_ADDR_STD, 1, 24'h050000);
        check(8'(acks[3]), 8'h01);
        check(ptr, 8'h05);
        write_xfer(TMS_ADDR_ALT, 1, 24'h090000);
        check(ptr, 8'h05);
        check(alt_ptr, 8'h09);
        foreach (bad[i])
        begin
            write_xfer(bad[i], 1, 24'h110000);
            check(8'(acks), 8'h00);
        end
        check(ptr, 8'h05);
        $display("test address done");
        read_xfer(TMS_ADDR_STD);
        check(8'(acks[3]), 8'h01);
        check(rd, 8'h05 ^ 8'hC3);
        read_xfer(TMS_ADDR_ALT);
        check(8'(acks[3]), 8'h01);
        check(rd, 8'h00);
        read_xfer(TMS_ADDR_STD);
        check(rd, 8'h05 ^ 8'hC3);
        $display("test read done");
        write_xfer(TMS_ADDR_STD, 2, {TMS_OFS_FILT, 16'h8E00});
        check(8'(acks), 8'h0E);
        check(8'(wr_cnt), 8'h01);
        check(last_wd, 8'h8E);
        check(8'(tmo_en), 8'h01);
        check(8'(filt), 8'h07);
        read_xfer(TMS_ADDR_STD);
        check(rd, 8'h8E);
        stall(1'h1);
        write_xfer(TMS_ADDR_STD, 2, {TMS_OFS_FILT, 16'h0200});
        check(8'(filt), 8'h01);
        stall(1'h0);
        $display("test timeout done");
        write_xfer(TMS_ADDR_STD, 3, {TMS_OFS_TRIG, 16'hA55A});
        check(8'(acks), 8'h0E);
        check(8'(trg_cnt), 8'h01);
        check(8'(wr_cnt), 8'h02);
        $display("test trigger done");
        rst_i = 1'h1;
        repeat (3) @(negedge clock_i);
        rst_i = 1'h0;
        repeat (4) @(negedge clock_i);
        check(ptr, TMS_PTR_RST);
        $display("test rereset done");
        conclude();
    end
endmodule

//--- testbench/tms_slave_monitor.sv
`timescale 1ns/10ps

// checker for the serial slave ports
module tms_slave_monitor
    import tms_pkg::*;
    #(
    parameter bit ALT_VARIANT = 1'h0,
    parameter int TMO_CYCLES  = TMS_TMO_CYC
    )
    (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // serial bus pins
    input  wire logic        serial_clock_i,
    input  wire logic        serial_data_line_i,
    input  wire logic        serial_data_line_oe_o,
    // register file side
    input  wire logic        reg_wr_o,
    input  wire logic [7:0]  reg_addr_o,
    input  wire logic [7:0]  reg_wdata_o,
    // one-shot and filter outputs
    input  wire logic        trigger_o,
    input  wire logic [2:0]  alert_filter_o,
    input  wire logic        timeout_en_o
    );

    logic scl_reg;    // last bus clock level
    logic sda_reg;    // last data level
    int   quiet_reg;  // cycles since a bus line edge

    // quiet time counter, saturates past the timeout
    always_ff @(posedge clock_i)
    begin
        scl_reg <= serial_clock_i;
        sda_reg <= serial_data_line_i;
        if (rst_i || scl_reg != serial_clock_i || sda_reg != serial_data_line_i)
            quiet_reg <= 0;
        else if (quiet_reg < TMO_CYCLES + 16)
            quiet_reg <= quiet_reg + 1;
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////
    // single trigger and store pulses, filter copy updates
    a_trig_one_pulse: assert property (trigger_o |=> !trigger_o)
        else $error("trigger longer than one cycle");
    a_trig_no_store: assert property (trigger_o |-> !reg_wr_o && reg_addr_o == TMS_OFS_TRIG)
        else $error("trigger with store or wrong pointer");
    a_wr_one_pulse: assert property (reg_wr_o |=> !reg_wr_o)
        else $error("write strobe longer than one cycle");
    a_wr_ptr_stable: assert property (reg_wr_o |-> $stable(reg_addr_o))
        else $error("pointer moved with data store");
    a_filt_load: assert property (reg_wr_o && reg_addr_o == TMS_OFS_FILT |-> ##[0:1]
        (timeout_en_o == reg_wdata_o[7] && alert_filter_o == reg_wdata_o[3:1]))
        else $error("filter copy not loaded");
    a_cfg_hold: assert property ($changed(timeout_en_o) || $changed(alert_filter_o)
        |-> reg_wr_o || $past(reg_wr_o))
        else $error("filter copy changed without write");
    // data drive moves in clock low
    a_oe_clk_low: assert property ($changed(serial_data_line_oe_o)
        |-> !$past(serial_clock_i, 2))
        else $error("data drive changed while clock high");
    a_tmo_release: assert property (timeout_en_o && quiet_reg >= TMO_CYCLES + 8
        |-> !serial_data_line_oe_o)
        else $error("line held past timeout");

    // main scenarios
    c_trigger: cover property (trigger_o);
    c_filt_write: cover property (reg_wr_o && reg_addr_o == TMS_OFS_FILT);
    c_timeout: cover property (timeout_en_o && quiet_reg == TMO_CYCLES + 8);
endmodule

bind tms_serial_slave tms_slave_monitor #(.ALT_VARIANT(ALT_VARIANT), .TMO_CYCLES(TMO_CYCLES)) mon
(
    .clock_i(clock_i), .rst_i(rst_i), .serial_clock_i(serial_clock_i),
    .serial_data_line_i(serial_data_line_i), .serial_data_line_oe_o(serial_data_line_oe_o),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .trigger_o(trigger_o), .alert_filter_o(alert_filter_o), .timeout_en_o(timeout_en_o)
);
